// ==== design/power_seq_ctrl.sv ====
// Reset, clock source, regulator, low-power mode sequencer with an edge event controller.
// Functional notes
// - After any reset the CPU clock comes from the internal 8 MHz oscillator.
// - A failing selected external 4-24 MHz clock forces return to internal oscillator.
// - Clock failure interrupt is raised only when its enable bit is set.
// - Boot pins are sampled at startup to choose flash, system memory or SRAM.
// - Supply below the reset threshold always holds the device in reset.
// - Enabled supply detector interrupts on falling, rising or both threshold crossings.
// - Run uses main regulation, stop main or low-power regulation, standby turns regulator off.
// - Regulator is on after every reset and off only in standby.
// - Sleep halts only the CPU clock; any interrupt or event wakes it.
// - Stop halts core clocks, PLL and fast oscillators, keeping state; regulator selectable.
// - Any event line, external, supply detector or alarm, wakes from stop.
// - Standby powers off core, PLL and fast oscillators; only standby logic keeps state.
// - Standby exits on reset pin, watchdog reset, wakeup rising edge or alarm.
// - Stop and standby leave the slow clocks for alarm and watchdog running.
// - Eighteen edge lines, each with rising, falling or both triggers and mask.
// - Detected unmasked requests are recorded in a readable pending register.
// - Edges are caught even when shorter than a peripheral bus clock period; here lines are sampled on REF_CLK, which also clocks the APB port.
// - Any of 80 GPIO pins can be routed onto the 16 external lines; here line n takes only pin n of one of the 5 ports (index port*16+n).
//
// Local design decisions: the APB slave port and the register offsets.
module power_seq_ctrl
  import power_seq_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input power_seq_pkg::apb_req_s APB_REQ,
  output power_seq_pkg::apb_rsp_s APB_RSP,
  input power_seq_pkg::pin_in_s PINS,
  input wire logic CPU_LOWPOWER_REQ,
  input wire logic CPU_IRQ_ANY,
  output logic CORE_RESET,
  output power_seq_pkg::boot_e BOOT_SEL,
  output power_seq_pkg::clk_ctrl_s CLK_CTRL,
  output power_seq_pkg::regulator_mode_e REG_MODE,
  output logic CLK_FAIL_IRQ,
  output logic SUPPLY_IRQ,
  output logic [N_LINES-1:0] EVENT_IRQ,
  output logic [2:0] PWR_STATE
);
  import power_seq_pkg::*;

  // Pin synchroniser; only the second stage is read by logic.
  pin_in_s sync1_reg;
  pin_in_s pins_s;
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      sync1_reg <= '0;
      pins_s <= '0;
    end
    else
    begin
      sync1_reg <= PINS;
      pins_s <= sync1_reg;
    end
  end

  // Previous synchronised levels for edge detection.
  logic wake_prev_reg;
  logic alarm_prev_reg;
  logic above_prev_reg;
  logic [N_LINES-1:0] line_prev_reg;

  pwr_state_e state_reg;
  pwr_state_e state_next;
  logic [7:0] hold_cnt_reg;
  logic [7:0] hold_cnt_next;

  logic ext_req_reg;
  logic fail_ie_reg;
  logic fail_flag_reg;
  logic src_ext_reg;
  logic pll_on_reg;
  logic [1:0] lp_mode_reg;
  logic lp_reg_reg;
  logic thr_en_reg;
  logic thr_rise_reg;
  logic thr_fall_reg;
  logic thr_flag_reg;
  logic standby_woke_reg;
  boot_e boot_reg;
  logic [N_LINES-1:0] mask_reg;
  logic [N_LINES-1:0] rise_reg;
  logic [N_LINES-1:0] fall_reg;
  logic [N_LINES-1:0] pend_reg;
  logic [ROUTE_W-1:0] route_reg [N_EXT_LINES];
  logic [DATA_W-1:0] prdata_reg;
  logic pslverr_reg;

  // APB decode.
  wire setup_phase = APB_REQ.psel && !APB_REQ.penable;
  wire wr_en = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  wire [ADDR_W-1:0] addr = APB_REQ.paddr;
  wire [DATA_W-1:0] wdata = APB_REQ.pwdata;
  wire sel_clk = (addr == CLK_CTRL_OFF);
  wire sel_pwr = (addr == PWR_CTRL_OFF);
  wire sel_stat = (addr == PWR_STAT_OFF);
  wire sel_mask = (addr == EVT_MASK_OFF);
  wire sel_rise = (addr == EVT_RISE_OFF);
  wire sel_fall = (addr == EVT_FALL_OFF);
  wire sel_pend = (addr == EVT_PEND_OFF);
  wire sel_rlo = (addr == ROUTE_LO_OFF);
  wire sel_rhi = (addr == ROUTE_HI_OFF);
  wire mapped = sel_clk | sel_pwr | sel_stat | sel_mask | sel_rise | sel_fall |
    sel_pend | sel_rlo | sel_rhi;

  // Reset causes; the supply supervisor cannot be masked by anything.
  wire supply_low = !pins_s.supply_ok;
  wire pin_reset = !pins_s.external_reset_pin_n;
  wire reset_cause = supply_low | pin_reset | pins_s.independent_watchdog_rst;

  wire wake_rise = pins_s.wakeup_pin && !wake_prev_reg;
  wire alarm_rise = pins_s.rtc_alarm && !alarm_prev_reg;
  wire standby_exit = wake_rise | alarm_rise;

  // Configuration lives in the core domain and is lost in standby, so the
  // reset sequence clears it as well.
  wire cfg_clr = (state_reg == ST_RESET);

  // Event line sources: routed GPIO, supply detector output, alarm.
  logic [N_LINES-1:0] line_src;
  genvar g;
  generate
    for (g = 0; g < N_EXT_LINES; g++)
    begin : g_line
      localparam int LREG = g / LINES_PER_ROUTE_REG;
      localparam int LBIT = (g % LINES_PER_ROUTE_REG) * ROUTE_FIELD;
      wire wr_route = wr_en && (LREG == 0 ? sel_rlo : sel_rhi);
      wire [ROUTE_W-1:0] port = (route_reg[g] < N_PORTS) ? route_reg[g] : '0;
      wire [6:0] gidx = {port, 4'(g)};
      assign line_src[g] = pins_s.gpio[gidx];
      always_ff @(posedge REF_CLK or posedge RST)
      begin
        if (RST)
          route_reg[g] <= '0;
        else if (cfg_clr)
          route_reg[g] <= '0;
        else if (wr_route)
          route_reg[g] <= wdata[LBIT +: ROUTE_W];
      end
    end
  endgenerate
  assign line_src[LINE_SUPPLY] = pins_s.supply_above;
  assign line_src[LINE_ALARM] = pins_s.rtc_alarm;

  // Sampling at the 200 MHz reference clock catches any pulse of one reference
  // period or more; the APB port runs on this same clock, so shorter pulses can be missed.
  wire [N_LINES-1:0] line_rise = line_src & ~line_prev_reg;
  wire [N_LINES-1:0] line_fall = ~line_src & line_prev_reg;
  wire [N_LINES-1:0] line_hit = ((line_rise & rise_reg) | (line_fall & fall_reg)) &
    mask_reg;
  wire [N_LINES-1:0] pend_clr = (wr_en && sel_pend) ? wdata[N_LINES-1:0] : '0;
  wire [N_LINES-1:0] pend_next = line_hit | (pend_reg & ~pend_clr);
  wire pend_any = |pend_reg;

  // Supply threshold crossing detection.
  wire above_rise = pins_s.supply_above && !above_prev_reg;
  wire above_fall = !pins_s.supply_above && above_prev_reg;
  wire thr_hit = thr_en_reg && ((above_rise && thr_rise_reg) ||
    (above_fall && thr_fall_reg));

  // External oscillator supervision.
  wire ext_fail = src_ext_reg && !pins_s.ext_osc_ok;
  wire lowpower_entry = (state_reg == ST_RUN) && CPU_LOWPOWER_REQ;
  wire stop_or_standby = (state_reg == ST_STOP) || (state_reg == ST_STANDBY);
  wire going_deep = lowpower_entry && (lp_mode_reg != LP_SLEEP);

  boot_e boot_pin_sel;
  assign boot_pin_sel = !pins_s.boot_pins[0] ? BOOT_USER_FLASH :
    (pins_s.boot_pins[1] ? BOOT_SRAM : BOOT_SYSTEM_MEM);

  // Power state sequencing.
  always_comb
  begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    case (state_reg)
      ST_RESET:
      begin
        if (reset_cause)
          hold_cnt_next = RESET_HOLD_CYC;
        else if (hold_cnt_reg == 8'h00)
          state_next = ST_RUN;
        else
          hold_cnt_next = hold_cnt_reg - 8'h01;
      end
      ST_RUN:
      begin
        if (CPU_LOWPOWER_REQ)
        begin
          if (lp_mode_reg == LP_STOP)
            state_next = ST_STOP;
          else if (lp_mode_reg == LP_STANDBY)
            state_next = ST_STANDBY;
          else
            state_next = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (CPU_IRQ_ANY || pend_any)
          state_next = ST_RUN;
      end
      ST_STOP:
      begin
        if (pend_any)
          state_next = ST_RUN;
      end
      ST_STANDBY:
      begin
        if (standby_exit)
        begin
          state_next = ST_RESET;
          hold_cnt_next = RESET_HOLD_CYC;
        end
      end
      default:
        state_next = ST_RESET;
    endcase
    if (reset_cause)
    begin
      state_next = ST_RESET;
      hold_cnt_next = RESET_HOLD_CYC;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= ST_RESET;
      hold_cnt_reg <= RESET_HOLD_CYC;
      wake_prev_reg <= 1'b0;
      alarm_prev_reg <= 1'b0;
      above_prev_reg <= 1'b0;
      line_prev_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      wake_prev_reg <= pins_s.wakeup_pin;
      alarm_prev_reg <= pins_s.rtc_alarm;
      above_prev_reg <= pins_s.supply_above;
      line_prev_reg <= line_src;
    end
  end

  // Boot pins are captured once, as the reset sequence releases the core.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      boot_reg <= BOOT_USER_FLASH;
    else if (state_reg == ST_RESET && state_next == ST_RUN)
      boot_reg <= boot_pin_sel;
  end

  // Standby circuitry keeps this flag across the reset sequence.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      standby_woke_reg <= 1'b0;
    else if (state_reg == ST_STANDBY && standby_exit && !reset_cause)
      standby_woke_reg <= 1'b1;
    else if (wr_en && sel_stat && wdata[PS_STANDBY_WOKE])
      standby_woke_reg <= 1'b0;
  end

  // Clock control register and source selection.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ext_req_reg <= 1'b0;
      fail_ie_reg <= 1'b0;
      fail_flag_reg <= 1'b0;
      src_ext_reg <= 1'b0;
      pll_on_reg <= 1'b0;
    end
    else if (cfg_clr)
    begin
      ext_req_reg <= 1'b0;
      fail_ie_reg <= 1'b0;
      fail_flag_reg <= 1'b0;
      src_ext_reg <= 1'b0;
      pll_on_reg <= 1'b0;
    end
    else
    begin
      if (ext_fail || going_deep)
        ext_req_reg <= 1'b0;
      else if (wr_en && sel_clk)
        ext_req_reg <= wdata[CC_EXT_REQ];
      if (wr_en && sel_clk)
        fail_ie_reg <= wdata[CC_FAIL_IE];
      if (ext_fail)
        fail_flag_reg <= 1'b1;
      else if (wr_en && sel_clk && wdata[CC_FAIL_FLAG])
        fail_flag_reg <= 1'b0;
      // A reset cause drops the external source at the same edge that enters reset.
      if (reset_cause || ext_fail || going_deep || !ext_req_reg)
        src_ext_reg <= 1'b0;
      else if (pins_s.ext_osc_ok)
        src_ext_reg <= 1'b1;
      if (wr_en && sel_clk)
        pll_on_reg <= wdata[CC_PLL_ON];
    end
  end

  // Power control register and supply detector flag.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      lp_mode_reg <= LP_SLEEP;
      lp_reg_reg <= 1'b0;
      thr_en_reg <= 1'b0;
      thr_rise_reg <= 1'b0;
      thr_fall_reg <= 1'b0;
      thr_flag_reg <= 1'b0;
    end
    else if (cfg_clr)
    begin
      lp_mode_reg <= LP_SLEEP;
      lp_reg_reg <= 1'b0;
      thr_en_reg <= 1'b0;
      thr_rise_reg <= 1'b0;
      thr_fall_reg <= 1'b0;
      thr_flag_reg <= 1'b0;
    end
    else
    begin
      if (wr_en && sel_pwr)
      begin
        lp_mode_reg <= wdata[PC_MODE_LSB +: 2];
        lp_reg_reg <= wdata[PC_LP_REG];
        thr_en_reg <= wdata[PC_THR_EN];
        thr_rise_reg <= wdata[PC_THR_RISE];
        thr_fall_reg <= wdata[PC_THR_FALL];
      end
      if (thr_hit)
        thr_flag_reg <= 1'b1;
      else if (wr_en && sel_pwr && wdata[PC_THR_FLAG])
        thr_flag_reg <= 1'b0;
    end
  end

  // Event controller configuration and pending bits.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      mask_reg <= '0;
      rise_reg <= '0;
      fall_reg <= '0;
      pend_reg <= '0;
    end
    else if (cfg_clr)
    begin
      mask_reg <= '0;
      rise_reg <= '0;
      fall_reg <= '0;
      pend_reg <= '0;
    end
    else
    begin
      if (wr_en && sel_mask)
        mask_reg <= wdata[N_LINES-1:0];
      if (wr_en && sel_rise)
        rise_reg <= wdata[N_LINES-1:0];
      if (wr_en && sel_fall)
        fall_reg <= wdata[N_LINES-1:0];
      pend_reg <= pend_next;
    end
  end

  // Read data is captured in the setup phase so the access phase answers at once.
  logic [DATA_W-1:0] route_lo_word;
  logic [DATA_W-1:0] route_hi_word;
  always_comb
  begin
    route_lo_word = '0;
    route_hi_word = '0;
    for (int i = 0; i < LINES_PER_ROUTE_REG; i++)
    begin
      route_lo_word[i*ROUTE_FIELD +: ROUTE_W] = route_reg[i];
      route_hi_word[i*ROUTE_FIELD +: ROUTE_W] = route_reg[i + LINES_PER_ROUTE_REG];
    end
  end

  wire [DATA_W-1:0] clk_word = DATA_W'({pll_on_reg, src_ext_reg, fail_flag_reg,
    fail_ie_reg, ext_req_reg});
  wire [DATA_W-1:0] pwr_word = DATA_W'({thr_flag_reg, thr_fall_reg, thr_rise_reg,
    thr_en_reg, lp_reg_reg, lp_mode_reg});
  wire [DATA_W-1:0] stat_word = DATA_W'({boot_reg, state_reg, standby_woke_reg,
    pins_s.supply_above});
  wire [DATA_W-1:0] rd_mux =
    sel_clk ? clk_word :
    sel_pwr ? pwr_word :
    sel_stat ? stat_word :
    sel_mask ? DATA_W'(mask_reg) :
    sel_rise ? DATA_W'(rise_reg) :
    sel_fall ? DATA_W'(fall_reg) :
    sel_pend ? DATA_W'(pend_reg) :
    sel_rlo ? route_lo_word :
    sel_rhi ? route_hi_word : '0;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_reg <= APB_REQ.pwrite ? '0 : rd_mux;
      pslverr_reg <= !mapped;
    end
  end

  assign APB_RSP.prdata = prdata_reg;
  assign APB_RSP.pready = 1'b1;
  assign APB_RSP.pslverr = pslverr_reg && APB_REQ.psel && APB_REQ.penable;

  // Output decode.
  assign CORE_RESET = (state_reg == ST_RESET);
  assign BOOT_SEL = boot_reg;
  assign CLK_CTRL.cpu_clk_en = (state_reg == ST_RUN);
  assign CLK_CTRL.core_clk_en = (state_reg == ST_RUN) || (state_reg == ST_SLEEP) ||
    (state_reg == ST_RESET);
  assign CLK_CTRL.internal_fast_oscillator_en = !stop_or_standby;
  assign CLK_CTRL.external_fast_oscillator_en = ext_req_reg && !stop_or_standby;
  assign CLK_CTRL.pll_en = pll_on_reg && !stop_or_standby;
  assign CLK_CTRL.sys_src_ext = src_ext_reg;
  // The slow oscillators feed the alarm and watchdog and never stop.
  assign CLK_CTRL.slow_clk_en = 1'b1;
  assign REG_MODE = (state_reg == ST_STANDBY) ? regulator_off :
    ((state_reg == ST_STOP && lp_reg_reg) ? low_power_regulation :
    main_regulation);
  assign CLK_FAIL_IRQ = fail_flag_reg && fail_ie_reg;
  assign SUPPLY_IRQ = thr_flag_reg;
  assign EVENT_IRQ = pend_reg;
  assign PWR_STATE = state_reg;

endmodule

// ==== design/power_seq_pkg.sv ====
// Constants, types and bundles shared by the power, reset and clock sequencer.
package power_seq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] CLK_CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] PWR_CTRL_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] PWR_STAT_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] EVT_MASK_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] EVT_RISE_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] EVT_FALL_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] EVT_PEND_OFF = 8'h18;
  localparam logic [ADDR_W-1:0] ROUTE_LO_OFF = 8'h1c;
  localparam logic [ADDR_W-1:0] ROUTE_HI_OFF = 8'h20;

  localparam int CC_EXT_REQ = 0;
  localparam int CC_FAIL_IE = 1;
  localparam int CC_FAIL_FLAG = 2;
  localparam int CC_SRC_EXT = 3;
  localparam int CC_PLL_ON = 4;

  localparam int PC_MODE_LSB = 0;
  localparam int PC_LP_REG = 2;
  localparam int PC_THR_EN = 3;
  localparam int PC_THR_RISE = 4;
  localparam int PC_THR_FALL = 5;
  localparam int PC_THR_FLAG = 6;

  localparam int PS_SUPPLY_ABOVE = 0;
  localparam int PS_STANDBY_WOKE = 1;
  localparam int PS_STATE_LSB = 2;
  localparam int PS_BOOT_LSB = 5;

  localparam int N_LINES = 18;
  localparam int N_EXT_LINES = 16;
  localparam int N_GPIO = 80;
  localparam logic [2:0] N_PORTS = 3'h5;
  localparam int ROUTE_W = 3;
  localparam int ROUTE_FIELD = 4;
  localparam int LINES_PER_ROUTE_REG = 8;
  localparam int LINE_SUPPLY = 16;
  localparam int LINE_ALARM = 17;

  localparam int REF_CLK_MHZ = 200;
  localparam int RESET_HOLD_NS = 1000;
  localparam logic [7:0] RESET_HOLD_CYC =
    8'((RESET_HOLD_NS * REF_CLK_MHZ + 999) / 1000);

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_STOP = 3'b011,
    ST_STANDBY = 3'b100
  } pwr_state_e;

  typedef enum logic [1:0] {
    LP_SLEEP = 2'b00,
    LP_STOP = 2'b01,
    LP_STANDBY = 2'b10
  } lowpower_mode_e;

  typedef enum logic [1:0] {
    main_regulation = 2'b00,
    low_power_regulation = 2'b01,
    regulator_off = 2'b10
  } regulator_mode_e;

  typedef enum logic [1:0] {
    BOOT_USER_FLASH = 2'b00,
    BOOT_SYSTEM_MEM = 2'b01,
    BOOT_SRAM = 2'b11
  } boot_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic core_clk_en;
    logic internal_fast_oscillator_en;
    logic external_fast_oscillator_en;
    logic pll_en;
    logic sys_src_ext;
    logic slow_clk_en;
  } clk_ctrl_s;

  typedef struct packed {
    logic [N_GPIO-1:0] gpio;
    logic wakeup_pin;
    logic external_reset_pin_n;
    logic independent_watchdog_rst;
    logic rtc_alarm;
    logic supply_ok;
    logic supply_above;
    logic ext_osc_ok;
    logic [1:0] boot_pins;
  } pin_in_s;

endpackage

// ==== testbench/power_seq_properties.sv ====
// Port-level checks for the power, reset and clock sequencer, bound into the design.
module power_seq_properties
(
  input wire logic REF_CLK,
  input wire logic RST,
  input power_seq_pkg::apb_req_s APB_REQ,
  input power_seq_pkg::apb_rsp_s APB_RSP,
  input power_seq_pkg::pin_in_s PINS,
  input wire logic CPU_LOWPOWER_REQ,
  input wire logic CPU_IRQ_ANY,
  input wire logic CORE_RESET,
  input power_seq_pkg::boot_e BOOT_SEL,
  input power_seq_pkg::clk_ctrl_s CLK_CTRL,
  input power_seq_pkg::regulator_mode_e REG_MODE,
  input wire logic CLK_FAIL_IRQ,
  input wire logic SUPPLY_IRQ,
  input wire logic [power_seq_pkg::N_LINES-1:0] EVENT_IRQ,
  input wire logic [2:0] PWR_STATE
);
  timeunit 1ns;
  timeprecision 100ps;
  import power_seq_pkg::*;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire low_st = (PWR_STATE == ST_STOP) || (PWR_STATE == ST_STANDBY);
  wire fast_on = CLK_CTRL.core_clk_en | CLK_CTRL.pll_en |
    CLK_CTRL.internal_fast_oscillator_en | CLK_CTRL.external_fast_oscillator_en;

  AST_RESET_SRC: assert property (CORE_RESET |-> !CLK_CTRL.sys_src_ext)
    else $error("external source selected in reset");
  AST_SUPPLY_RST: assert property (!PINS.supply_ok [*4] |=> CORE_RESET)
    else $error("low supply not holding reset");
  AST_REG_OFF: assert property (
    (REG_MODE == regulator_off) == (PWR_STATE == ST_STANDBY))
    else $error("regulator off outside standby");
  AST_REG_RUN: assert property (PWR_STATE == ST_RUN |-> REG_MODE == main_regulation)
    else $error("run without main regulation");
  AST_SLEEP_CLK: assert property (
    PWR_STATE == ST_SLEEP |-> !CLK_CTRL.cpu_clk_en && CLK_CTRL.core_clk_en)
    else $error("sleep clocks wrong");
  AST_LOW_CLK: assert property (low_st |-> !fast_on && CLK_CTRL.slow_clk_en)
    else $error("clocks left running in stop or standby");
  AST_FAIL_SWITCH: assert property (
    CLK_CTRL.sys_src_ext && !PINS.ext_osc_ok |-> ##[1:4] !CLK_CTRL.sys_src_ext)
    else $error("no fallback on oscillator failure");
  AST_STOP_WAKE: assert property (
    PWR_STATE == ST_STOP && EVENT_IRQ != 0 |-> ##[1:2] PWR_STATE == ST_RUN)
    else $error("pending event did not end stop");
  AST_STANDBY_EXIT: assert property (
    PWR_STATE == ST_STANDBY && $rose(PINS.wakeup_pin) |-> ##[1:6] CORE_RESET)
    else $error("wakeup rise did not leave standby");

  cover property (PWR_STATE == ST_SLEEP);
  cover property (PWR_STATE == ST_STOP);
  cover property (PWR_STATE == ST_STANDBY);
  cover property (CLK_FAIL_IRQ);
endmodule

bind power_seq_ctrl power_seq_properties chk (
  .REF_CLK(REF_CLK), .RST(RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .PINS(PINS),
  .CPU_LOWPOWER_REQ(CPU_LOWPOWER_REQ), .CPU_IRQ_ANY(CPU_IRQ_ANY), .CORE_RESET(CORE_RESET),
  .BOOT_SEL(BOOT_SEL), .CLK_CTRL(CLK_CTRL), .REG_MODE(REG_MODE), .CLK_FAIL_IRQ(CLK_FAIL_IRQ),
  .SUPPLY_IRQ(SUPPLY_IRQ), .EVENT_IRQ(EVENT_IRQ), .PWR_STATE(PWR_STATE)
);

// ==== testbench/power_seq_pin_model.sv ====
// Board-side pins: supply, oscillator, reset, watchdog, wakeup, alarm and GPIO levels.
module power_seq_pin_model
(
  input wire logic REF_CLK,
  output power_seq_pkg::pin_in_s PINS
);
  timeunit 1ns;
  timeprecision 100ps;
  import power_seq_pkg::*;
  initial
  begin
    PINS = '0;
    PINS.external_reset_pin_n = 1'b1;
    PINS.supply_ok = 1'b1;
    PINS.supply_above = 1'b1;
    PINS.ext_osc_ok = 1'b1;
  end
  // A cause is asserted (v=1) or removed after the next edge; k=5 (ext_osc_ok) and the default (supply_above) take the level v directly.
  task automatic drive(input int k, input logic v);
    @(posedge REF_CLK);
    case (k)
      0: PINS.wakeup_pin <= v;
      1: PINS.external_reset_pin_n <= !v;
      2: PINS.independent_watchdog_rst <= v;
      3: PINS.rtc_alarm <= v;
      4: PINS.supply_ok <= !v;
      5: PINS.ext_osc_ok <= v;
      default: PINS.supply_above <= v;
    endcase
  endtask
endmodule

// ==== testbench/power_seq_ctrl_tb.sv ====
// Self-checking bench for the power, reset and clock sequencer.
module power_seq_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import power_seq_pkg::*;
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic lp_req = 1'b0;
  logic irq_any = 1'b0;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  pin_in_s pins;
  logic core_reset;
  boot_e boot_sel;
  clk_ctrl_s clk;
  regulator_mode_e reg_mode;
  logic fail_irq;
  logic supply_irq;
  logic [N_LINES-1:0] ev_irq;
  logic [2:0] st;
  logic [31:0] rd;
  logic rd_err;
  int errors = 0;
  int cmp_count = 0;

  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  power_seq_pin_model env (.REF_CLK(ref_clk), .PINS(pins));
  power_seq_ctrl uut (
    .REF_CLK(ref_clk), .RST(rst), .APB_REQ(req), .APB_RSP(rsp), .PINS(pins),
    .CPU_LOWPOWER_REQ(lp_req), .CPU_IRQ_ANY(irq_any), .CORE_RESET(core_reset),
    .BOOT_SEL(boot_sel), .CLK_CTRL(clk), .REG_MODE(reg_mode), .CLK_FAIL_IRQ(fail_irq),
    .SUPPLY_IRQ(supply_irq), .EVENT_IRQ(ev_irq), .PWR_STATE(st)
  );

  task automatic complete_run();
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One idle edge closes each transfer so the next setup is never written in the same step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    rd_err = rsp.pslverr;
    req <= '0;
    if (n >= 20)
    begin
      errors++;
      complete_run();
    end
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_state(input logic [2:0] s, output int n);
    n = 0;
    while (st !== s)
    begin
      @(posedge ref_clk);
      n++;
      if (n > 1000)
      begin
        errors++;
        complete_run();
      end
    end
  endtask

  task automatic lowpower(input logic [31:0] mode);
    wr(PWR_CTRL_OFF, mode);
    lp_req <= 1'b1;
    @(posedge ref_clk);
    lp_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic t_boot();
    boot_e codes[3] = '{BOOT_USER_FLASH, BOOT_SYSTEM_MEM, BOOT_SRAM};
    int n;
    foreach (codes[i])
    begin
      env.PINS.boot_pins <= codes[i];
      env.drive(1, 1'b1);
      repeat (4) @(posedge ref_clk);
      env.drive(1, 1'b0);
      wait_state(ST_RUN, n);
      `CHK("hold", 1'b1, 1'(n >= RESET_HOLD_CYC))
      `CHK("boot", codes[i], boot_sel)
      `CHK("src", 1'b0, clk.sys_src_ext)
      `CHK("reg", main_regulation, reg_mode)
      rdr(PWR_STAT_OFF);
      `CHK("stat", ({codes[i], ST_RUN}), rd[6:2])
    end
  endtask

  task automatic t_supply();
    int n;
    wr(EVT_MASK_OFF, 32'h3);
    env.drive(4, 1'b1);
    repeat (6) @(posedge ref_clk);
    `CHK("rst", 1'b1, core_reset)
    env.drive(4, 1'b0);
    wait_state(ST_RUN, n);
    rdr(EVT_MASK_OFF);
    `CHK("mask", 32'h0, rd)
    rdr(8'h40);
    `CHK("slverr", 1'b1, rd_err)
  endtask

  task automatic t_clk();
    wr(CLK_CTRL_OFF, 32'h1);
    repeat (5) @(posedge ref_clk);
    `CHK("ext", 1'b1, clk.sys_src_ext)
    env.drive(5, 1'b0);
    repeat (5) @(posedge ref_clk);
    `CHK("back", 1'b0, clk.sys_src_ext)
    `CHK("irq off", 1'b0, fail_irq)
    rdr(CLK_CTRL_OFF);
    `CHK("flag", 3'h4, rd[2:0])
    env.drive(5, 1'b1);
    wr(CLK_CTRL_OFF, 32'h2);
    `CHK("irq on", 1'b1, fail_irq)
    wr(CLK_CTRL_OFF, 32'h6);
    `CHK("irq clr", 1'b0, fail_irq)
  endtask

  task automatic t_thr();
    logic [7:0] cfg[4] = '{8'h18, 8'h28, 8'h38, 8'h30};
    foreach (cfg[i])
    begin
      wr(PWR_CTRL_OFF, {24'h0, cfg[i] | 8'h40});
      env.drive(6, 1'b0);
      repeat (6) @(posedge ref_clk);
      `CHK("fall", cfg[i][3] & cfg[i][5], supply_irq)
      wr(PWR_CTRL_OFF, {24'h0, cfg[i] | 8'h40});
      env.drive(6, 1'b1);
      repeat (6) @(posedge ref_clk);
      `CHK("rise", cfg[i][3] & cfg[i][4], supply_irq)
    end
  endtask

  // Line 9 taken from port 4, the highest port, so gpio index 4*16+9.
  task automatic t_events();
    logic [2:0] cfg[4] = '{3'b110, 3'b101, 3'b111, 3'b011};
    wr(ROUTE_HI_OFF, 32'h40);
    foreach (cfg[i])
    begin
      wr(EVT_MASK_OFF, 32'(cfg[i][2]) << 9);
      wr(EVT_RISE_OFF, 32'(cfg[i][1]) << 9);
      wr(EVT_FALL_OFF, 32'(cfg[i][0]) << 9);
      env.PINS.gpio[73] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      `CHK("up", cfg[i][2] & cfg[i][1], ev_irq[9])
      rdr(EVT_PEND_OFF);
      `CHK("pend", cfg[i][2] & cfg[i][1], rd[9])
      wr(EVT_PEND_OFF, 32'h200);
      env.PINS.gpio[73] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      `CHK("down", cfg[i][2] & cfg[i][0], ev_irq[9])
      wr(EVT_PEND_OFF, 32'h200);
    end
    wr(EVT_MASK_OFF, 32'h200);
    env.PINS.gpio[73] <= 1'b1;
    @(posedge ref_clk);
    env.PINS.gpio[73] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK("short", 1'b1, ev_irq[9])
    wr(EVT_PEND_OFF, 32'h200);
  endtask

  task automatic t_sleep();
    int n;
    lowpower(32'h0);
    `CHK("sleep", ST_SLEEP, st)
    `CHK("cpu", 1'b0, clk.cpu_clk_en)
    `CHK("core", 1'b1, clk.core_clk_en)
    irq_any <= 1'b1;
    wait_state(ST_RUN, n);
    irq_any <= 1'b0;
  endtask

  task automatic t_stop();
    int n;
    wr(EVT_MASK_OFF, 32'h20000);
    wr(EVT_RISE_OFF, 32'h20000);
    wr(CLK_CTRL_OFF, 32'h11);
    lowpower(32'h5);
    `CHK("stop", ST_STOP, st)
    `CHK("lpr", low_power_regulation, reg_mode)
    `CHK("pll", 1'b0, clk.pll_en)
    `CHK("slow", 1'b1, clk.slow_clk_en)
    env.drive(3, 1'b1);
    env.drive(3, 1'b0);
    wait_state(ST_RUN, n);
    rdr(EVT_MASK_OFF);
    `CHK("kept", 32'h20000, rd)
    wr(EVT_PEND_OFF, 32'h20000);
  endtask

  task automatic t_standby();
    int src[4] = '{0, 3, 2, 1};
    int n;
    foreach (src[i])
    begin
      wr(EVT_MASK_OFF, 32'h1);
      wr(CLK_CTRL_OFF, 32'h1);
      repeat (5) @(posedge ref_clk);
      lowpower(32'h2);
      `CHK("stby", ST_STANDBY, st)
      `CHK("off", regulator_off, reg_mode)
      `CHK("osc", 1'b0, clk.internal_fast_oscillator_en)
      env.drive(src[i], 1'b1);
      env.drive(src[i], 1'b0);
      wait_state(ST_RESET, n);
      wait_state(ST_RUN, n);
      `CHK("src", 1'b0, clk.sys_src_ext)
      rdr(EVT_MASK_OFF);
      `CHK("lost", 32'h0, rd)
    end
  endtask

  initial
  begin
    int n;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    wait_state(ST_RUN, n);
    t_boot();
    t_supply();
    t_clk();
    t_thr();
    t_events();
    t_sleep();
    t_stop();
    t_standby();
    complete_run();
  end
endmodule
